// >>> atw_defines.svh
// Summary of operation
// - fault when VA bits 63:47 are neither all zeros nor all ones.
// - with tagging on, top eight VA bits are ignored.
// - VA 63:42 all ones picks kernel base, all zeros picks user base.
// - level 2 table has 8192 64-bit entries indexed by VA 41:29.
// - every fetched entry is checked for validity and access permission.
// - 512MB block: PA 47:29 from entry, PA 28:0 from VA.
// - completion returns the 48-bit PA with descriptor attributes.
// - level 2 table entry bits 47:16 give the level 3 table base.
// - level 3 table indexed by VA 28:16, entry fetched from memory.
// - 64KB page: PA 47:16 from entry, PA 15:0 from VA.
// - several entries may point to one shared next-level table.
// - Normal-world accesses only reach the Non-secure space.
// - Secure and Non-secure copies of one address are distinct addresses.
// - control writes take effect only at a synchronisation event.
// - translation is enabled by system control bit 0.
// - instruction after enable runs at VA+4, so that code is flat-mapped.
// - translation off with default-cacheable set gives Normal write-back attributes to non-secure requests only.
// - output address beyond the output size field limit faults.
`ifndef ATW_DEFINES_SVH
`define ATW_DEFINES_SVH
`define ATW_VA_TOP 63
`define ATW_VA_CHK_LO 47
`define ATW_VA_SEL_LO 42
`define ATW_TAG_LO 56
`define ATW_L2_IDX_HI 41
`define ATW_L2_IDX_LO 29
`define ATW_L3_IDX_HI 28
`define ATW_L3_IDX_LO 16
`define ATW_PA_HI 47
`define ATW_DESC_VALID 0
`define ATW_DESC_TABLE 1
`define ATW_DESC_AP_RO 7
`define ATW_DESC_AP_USER 6
`define ATW_DESC_NS 5
`define ATW_SCTL_EN 0
`define ATW_IPS_32 3'h0
`define ATW_IPS_36 3'h1
`define ATW_IPS_40 3'h2
`define ATW_IPS_42 3'h3
`define ATW_IPS_44 3'h4
`define ATW_IPS_48 3'h5
`define ATW_ATTR_WBRWA 8'hff
`define ATW_ATTR_DEVICE 8'h00
`endif

// >>> atw_desc_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "atw_defines.svh"
module atw_desc_check (
    input wire logic [63:0] desc_i,
    input wire logic is_write_i,
    input wire logic is_user_i,
    input wire logic is_l3_i,
    output logic ok_o,
    output logic is_table_o
);
    // level 3 needs type bits 11, so bit 1 clear there is invalid
    always_comb begin
        ok_o = desc_i[`ATW_DESC_VALID];
        if (is_l3_i && !desc_i[`ATW_DESC_TABLE]) begin
            ok_o = 1'b0;
        end
        if (is_write_i && desc_i[`ATW_DESC_AP_RO]) begin
            ok_o = 1'b0;
        end
        if (is_user_i && !desc_i[`ATW_DESC_AP_USER]) begin
            ok_o = 1'b0;
        end
        is_table_o = !is_l3_i && desc_i[`ATW_DESC_TABLE];
    end
endmodule
`default_nettype wire

// >>> atw_pa_limit.sv
`timescale 1ns/1ps
`default_nettype none
`include "atw_defines.svh"
module atw_pa_limit (
    input wire logic [47:0] pa_i,
    input wire logic [2:0] output_size_field_i,
    output logic over_o
);
    function automatic logic over_bits(input logic [47:0] pa, input int unsigned w);
        logic [47:0] mask;
        mask = ~((48'h1 << w) - 48'h1);
        over_bits = |(pa & mask);
    endfunction
    always_comb begin
        unique case (output_size_field_i)
            `ATW_IPS_32: over_o = over_bits(pa_i, 32);
            `ATW_IPS_36: over_o = over_bits(pa_i, 36);
            `ATW_IPS_40: over_o = over_bits(pa_i, 40);
            `ATW_IPS_42: over_o = over_bits(pa_i, 42);
            `ATW_IPS_44: over_o = over_bits(pa_i, 44);
            `ATW_IPS_48: over_o = 1'b0;
            default: over_o = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// >>> atw_pkg.sv
package atw_pkg;
    typedef enum logic [2:0] {
        ATW_IDLE,
        ATW_L2_REQ,
        ATW_L2_WAIT,
        ATW_L3_REQ,
        ATW_L3_WAIT,
        ATW_DONE
    } atw_state_t;
    typedef enum logic [2:0] {
        ATW_F_NONE,
        ATW_F_VA_RANGE,
        ATW_F_L2,
        ATW_F_L3,
        ATW_F_SIZE,
        ATW_F_SECURITY
    } atw_fault_t;
endpackage

// >>> atw_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
module atw_table_mem (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic mem_req_i,
    input wire logic [47:0] mem_addr_i,
    input wire logic [3:0] delay_i,
    output logic mem_ack_o,
    output logic [63:0] mem_data_o
);
    // ----
    // descriptor store, absent entries read as zero (invalid)
    // ----
    logic [63:0] store [logic [47:0]];
    logic [47:0] addr_reg;
    logic [3:0] wait_reg;
    logic busy_reg;
    always_ff @(posedge clk_sys_i) begin
        mem_ack_o <= 1'b0;
        // data never held past the ack, so a late sample cannot pass
        mem_data_o <= ~mem_data_o;
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            mem_data_o <= 64'h0;
        end else if (mem_req_i) begin
            busy_reg <= 1'b1;
            addr_reg <= mem_addr_i;
            wait_reg <= delay_i;
        end else if (busy_reg && wait_reg == 4'h0) begin
            busy_reg <= 1'b0;
            mem_ack_o <= 1'b1;
            mem_data_o <= store.exists(addr_reg) ? store[addr_reg] : 64'h0;
        end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> atw_walker.sv
`timescale 1ns/1ps
`default_nettype none
`include "atw_defines.svh"
module atw_walker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [63:0] req_va_i,
    input wire logic req_write_i,
    input wire logic req_user_i,
    input wire logic req_secure_i,
    input wire logic [47:0] user_table_base_reg_i,
    input wire logic [47:0] kernel_table_base_reg_i,
    input wire logic [2:0] output_size_field_i,
    input wire logic tag_enable_i,
    input wire logic [63:0] system_control_i,
    input wire logic hyp_default_cacheable_i,
    input wire logic instruction_sync_barrier_i,
    output logic mem_req_o,
    output logic [47:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [63:0] mem_data_i,
    output logic rsp_valid_o,
    output logic [47:0] rsp_pa_o,
    output logic rsp_ns_o,
    output logic [63:0] rsp_attr_o,
    output logic rsp_fault_o,
    output logic [2:0] rsp_fault_code_o,
    output logic translation_on_o
);
    // ----------------------------------------------------------------
    // shadow control, latched only at sync events
    // ----------------------------------------------------------------
    logic [47:0] ubase_reg, ubase_next;
    logic [47:0] kbase_reg, kbase_next;
    logic [2:0] osize_reg, osize_next;
    logic tag_reg, tag_next;
    logic en_reg, en_next;
    logic dc_reg, dc_next;
    // live register writes are invisible to walks until a barrier
    always_comb begin
        ubase_next = ubase_reg;
        kbase_next = kbase_reg;
        osize_next = osize_reg;
        tag_next = tag_reg;
        en_next = en_reg;
        dc_next = dc_reg;
        if (instruction_sync_barrier_i) begin
            ubase_next = user_table_base_reg_i;
            kbase_next = kernel_table_base_reg_i;
            osize_next = output_size_field_i;
            tag_next = tag_enable_i;
            en_next = system_control_i[`ATW_SCTL_EN];
            dc_next = hyp_default_cacheable_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ubase_reg <= 48'h0;
            kbase_reg <= 48'h0;
            osize_reg <= `ATW_IPS_32;
            tag_reg <= 1'b0;
            en_reg <= 1'b0;
            dc_reg <= 1'b0;
        end else begin
            ubase_reg <= ubase_next;
            kbase_reg <= kbase_next;
            osize_reg <= osize_next;
            tag_reg <= tag_next;
            en_reg <= en_next;
            dc_reg <= dc_next;
        end
    end
    assign translation_on_o = en_reg;

    // ----------------------------------------------------------------
    // walk state
    // ----------------------------------------------------------------
    atw_pkg::atw_state_t state_reg, state_next;
    logic [63:0] va_reg, va_next;
    logic wr_reg, wr_next, usr_reg, usr_next, sec_reg, sec_next;
    logic [47:0] maddr_reg, maddr_next;
    logic [47:0] pa_reg, pa_next;
    logic ns_reg, ns_next;
    logic [63:0] attr_reg, attr_next;
    logic fault_reg, fault_next;
    logic [2:0] fcode_reg, fcode_next;

    logic desc_ok, desc_table, pa_over;
    logic [47:0] cand_pa;
    logic cand_ns;
    logic [63:0] va_eff;
    logic va_in_range, va_sel_ok, sel_ones;

    // ----------------------------------------------------------------
    // helpers for table entry addresses and VA range checks
    // ----------------------------------------------------------------
    // byte address of one 8-byte entry inside a table
    function automatic logic [47:0] entry_addr(input logic [47:0] base, input logic [12:0] idx);
        entry_addr = base + {32'h0, idx, 3'h0};
    endfunction

    // every bit from lo up to the top is a copy of the top bit
    function automatic logic sign_uniform(input logic [63:0] va, input int unsigned lo);
        logic [63:0] mask;
        mask = ~64'h0 << lo;
        sign_uniform = ((va & mask) == 64'h0) || ((va & mask) == mask);
    endfunction

    // ----------------------------------------------------------------
    // virtual address checks
    // ----------------------------------------------------------------
    // tagged pointers: top byte replaced by a sign copy of bit 55
    always_comb begin
        va_eff = req_va_i;
        if (tag_reg) begin
            va_eff[`ATW_VA_TOP:`ATW_TAG_LO] = {8{req_va_i[`ATW_TAG_LO - 1]}};
        end
        va_in_range = sign_uniform(va_eff, `ATW_VA_CHK_LO);
        va_sel_ok = sign_uniform(va_eff, `ATW_VA_SEL_LO);
        // only meaningful once va_sel_ok holds
        sel_ones = va_eff[`ATW_VA_TOP];
    end

    // ----------------------------------------------------------------
    // descriptor checks
    // ----------------------------------------------------------------
    atw_desc_check u_check (
        .desc_i(mem_data_i),
        .is_write_i(wr_reg),
        .is_user_i(usr_reg),
        .is_l3_i(state_reg == atw_pkg::ATW_L3_WAIT),
        .ok_o(desc_ok),
        .is_table_o(desc_table)
    );

    // ----------------------------------------------------------------
    // leaf address and output size
    // ----------------------------------------------------------------
    // candidate output address for the fetched leaf entry
    always_comb begin
        if (state_reg == atw_pkg::ATW_L3_WAIT) begin
            cand_pa = {mem_data_i[`ATW_PA_HI:`ATW_L3_IDX_LO],
                       va_reg[`ATW_L3_IDX_LO-1:0]};
        end else begin
            cand_pa = {mem_data_i[`ATW_PA_HI:`ATW_L2_IDX_LO],
                       va_reg[`ATW_L2_IDX_LO-1:0]};
        end
        // normal world is forced onto the non-secure space
        cand_ns = !sec_reg || mem_data_i[`ATW_DESC_NS];
    end

    atw_pa_limit u_limit (
        .pa_i(cand_pa),
        .output_size_field_i(osize_reg),
        .over_o(pa_over)
    );

    // ----------------------------------------------------------------
    // walk sequencing
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        va_next = va_reg;
        wr_next = wr_reg;
        usr_next = usr_reg;
        sec_next = sec_reg;
        maddr_next = maddr_reg;
        pa_next = pa_reg;
        ns_next = ns_reg;
        attr_next = attr_reg;
        fault_next = fault_reg;
        fcode_next = fcode_reg;
        unique case (state_reg)
            atw_pkg::ATW_IDLE: begin
                if (req_valid_i) begin
                    va_next = va_eff;
                    wr_next = req_write_i;
                    usr_next = req_user_i;
                    sec_next = req_secure_i;
                    fault_next = 1'b0;
                    fcode_next = atw_pkg::ATW_F_NONE;
                    attr_next = 64'h0;
                    // normal world stays non-secure even on a fault
                    ns_next = !req_secure_i;
                    state_next = atw_pkg::ATW_DONE;
                    if (!en_reg) begin
                        // flat map; code after the enable relies on this
                        pa_next = va_eff[`ATW_PA_HI:0];
                        attr_next[7:0] = (dc_reg && !req_secure_i) ?
                            `ATW_ATTR_WBRWA : `ATW_ATTR_DEVICE;
                    end else if (!va_in_range) begin
                        fault_next = 1'b1;
                        fcode_next = atw_pkg::ATW_F_VA_RANGE;
                    end else if (!va_sel_ok) begin
                        fault_next = 1'b1;
                        fcode_next = atw_pkg::ATW_F_VA_RANGE;
                    end else begin
                        // 13-bit index, 8-byte entries: 8192 entries
                        maddr_next = entry_addr(sel_ones ? kbase_reg : ubase_reg,
                            va_eff[`ATW_L2_IDX_HI:`ATW_L2_IDX_LO]);
                        state_next = atw_pkg::ATW_L2_REQ;
                    end
                end
            end
            atw_pkg::ATW_L2_REQ: begin
                state_next = atw_pkg::ATW_L2_WAIT;
            end
            atw_pkg::ATW_L2_WAIT: begin
                if (mem_ack_i) begin
                    attr_next = mem_data_i;
                    if (!desc_ok) begin
                        fault_next = 1'b1;
                        fcode_next = atw_pkg::ATW_F_L2;
                        state_next = atw_pkg::ATW_DONE;
                    end else if (desc_table) begin
                        // no memo of tables, so shared tables just work
                        maddr_next = entry_addr({mem_data_i[`ATW_PA_HI:`ATW_L3_IDX_LO], 16'h0},
                            va_reg[`ATW_L3_IDX_HI:`ATW_L3_IDX_LO]);
                        state_next = atw_pkg::ATW_L3_REQ;
                    end else begin
                        pa_next = cand_pa;
                        ns_next = cand_ns;
                        fault_next = pa_over;
                        fcode_next = pa_over ? atw_pkg::ATW_F_SIZE : atw_pkg::ATW_F_NONE;
                        state_next = atw_pkg::ATW_DONE;
                    end
                end
            end
            atw_pkg::ATW_L3_REQ: begin
                state_next = atw_pkg::ATW_L3_WAIT;
            end
            atw_pkg::ATW_L3_WAIT: begin
                if (mem_ack_i) begin
                    attr_next = mem_data_i | attr_reg;
                    state_next = atw_pkg::ATW_DONE;
                    if (!desc_ok) begin
                        fault_next = 1'b1;
                        fcode_next = atw_pkg::ATW_F_L3;
                    end else begin
                        pa_next = cand_pa;
                        ns_next = cand_ns;
                        fault_next = pa_over;
                        fcode_next = pa_over ? atw_pkg::ATW_F_SIZE : atw_pkg::ATW_F_NONE;
                    end
                end
            end
            atw_pkg::ATW_DONE: begin
                state_next = atw_pkg::ATW_IDLE;
            end
            default: state_next = atw_pkg::ATW_IDLE;
        endcase
        if (fault_next) begin
            pa_next = 48'h0;
        end
    end

    // ----------------------------------------------------------------
    // walk registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_reg <= atw_pkg::ATW_IDLE;
            va_reg <= 64'h0;
            wr_reg <= 1'b0;
            usr_reg <= 1'b0;
            sec_reg <= 1'b0;
            maddr_reg <= 48'h0;
            pa_reg <= 48'h0;
            ns_reg <= 1'b1;
            attr_reg <= 64'h0;
            fault_reg <= 1'b0;
            fcode_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            va_reg <= va_next;
            wr_reg <= wr_next;
            usr_reg <= usr_next;
            sec_reg <= sec_next;
            maddr_reg <= maddr_next;
            pa_reg <= pa_next;
            ns_reg <= ns_next;
            attr_reg <= attr_next;
            fault_reg <= fault_next;
            fcode_reg <= fcode_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_ready_o = (state_reg == atw_pkg::ATW_IDLE);
    assign mem_req_o = (state_reg == atw_pkg::ATW_L2_REQ) ||
                       (state_reg == atw_pkg::ATW_L3_REQ);
    assign mem_addr_o = maddr_reg;
    assign rsp_valid_o = (state_reg == atw_pkg::ATW_DONE);
    assign rsp_pa_o = pa_reg;
    assign rsp_ns_o = ns_reg;
    assign rsp_attr_o = attr_reg;
    assign rsp_fault_o = fault_reg;
    assign rsp_fault_code_o = fcode_reg;
endmodule
`default_nettype wire

// >>> atw_walker_props.sv
`timescale 1ns/1ps
`default_nettype none
module atw_walker_props (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [63:0] req_va_i,
    input wire logic req_secure_i,
    input wire logic tag_enable_i,
    input wire logic [63:0] system_control_i,
    input wire logic hyp_default_cacheable_i,
    input wire logic instruction_sync_barrier_i,
    input wire logic mem_req_o,
    input wire logic [47:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [63:0] mem_data_i,
    input wire logic rsp_valid_o,
    input wire logic [47:0] rsp_pa_o,
    input wire logic rsp_ns_o,
    input wire logic [63:0] rsp_attr_o,
    input wire logic rsp_fault_o,
    input wire logic [2:0] rsp_fault_code_o,
    input wire logic translation_on_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // own copy of synced controls and of the walk in flight
    // ----
    logic on_reg, tag_reg, dc_reg, sec_reg;
    logic [1:0] nreq_reg;
    logic [63:0] va_reg, ack_reg, eva;
    logic take;
    assign take = req_valid_i && req_ready_o;
    assign eva = tag_reg ? {{8{req_va_i[55]}}, req_va_i[55:0]} : req_va_i;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            on_reg <= 1'b0;
            tag_reg <= 1'b0;
            dc_reg <= 1'b0;
            nreq_reg <= 2'h0;
        end else begin
            if (instruction_sync_barrier_i) begin
                on_reg <= system_control_i[0];
                tag_reg <= tag_enable_i;
                dc_reg <= hyp_default_cacheable_i;
            end
            if (take) begin
                va_reg <= eva;
                sec_reg <= req_secure_i;
                nreq_reg <= 2'h0;
            end else if (mem_req_o) begin
                nreq_reg <= nreq_reg + 2'h1;
            end
            if (mem_ack_i) begin
                ack_reg <= mem_data_i;
            end
        end
    end
    chk_va_range: assert property (take && on_reg && !(&eva[63:47]) && |eva[63:47]
        |-> ##1 rsp_valid_o && !mem_req_o && rsp_fault_code_o == 3'h1) else $error("no range fault");
    chk_l3_addr: assert property (mem_req_o && nreq_reg == 2'h1 |-> mem_addr_o ==
        {ack_reg[47:16], 16'h0} + {32'h0, va_reg[28:16], 3'h0}) else $error("bad level 3 fetch");
    chk_blk_pa: assert property (rsp_valid_o && !rsp_fault_o && on_reg && nreq_reg == 2'h1
        |-> rsp_pa_o == {ack_reg[47:29], va_reg[28:0]}) else $error("bad block address");
    chk_page_pa: assert property (rsp_valid_o && !rsp_fault_o && nreq_reg == 2'h2
        |-> rsp_pa_o == {ack_reg[47:16], va_reg[15:0]}) else $error("bad page address");
    chk_off_flat: assert property (take && !on_reg |-> ##1 rsp_valid_o && !rsp_fault_o
        && rsp_pa_o == va_reg[47:0] && rsp_attr_o[7:0] == (dc_reg && !sec_reg ? 8'hff : 8'h00))
        else $error("bad flat response");
    chk_rsp_pulse: assert property (rsp_valid_o |-> !req_ready_o ##1 req_ready_o && !rsp_valid_o)
        else $error("response not one pulse");
    chk_ns_normal: assert property (rsp_valid_o && !sec_reg |-> rsp_ns_o)
        else $error("normal world left non-secure space");
    chk_bad_abort: assert property (mem_ack_i && !mem_data_i[0] && !req_ready_o
        |-> ##[1:2] rsp_valid_o && rsp_fault_o && rsp_pa_o == 48'h0) else $error("no abort");
    chk_sync_on: assert property (instruction_sync_barrier_i |=>
        translation_on_o == $past(system_control_i[0])) else $error("enable not taken");
    chk_hold_on: assert property (!instruction_sync_barrier_i |=> $stable(translation_on_o))
        else $error("enable moved without sync");
    cov_page: cover property (rsp_valid_o && nreq_reg == 2'h2);
    cov_block: cover property (rsp_valid_o && nreq_reg == 2'h1);
    cov_fault: cover property (rsp_valid_o && rsp_fault_o);
endmodule
bind atw_walker atw_walker_props u_props (.*);
`default_nettype wire

// >>> atw_walker_tb.sv
`timescale 1ns/1ps
`default_nettype none
module atw_walker_tb;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic req_user_i = 1'b0, req_secure_i = 1'b0, tag_enable_i = 1'b0;
    logic hyp_default_cacheable_i = 1'b1, instruction_sync_barrier_i = 1'b0;
    logic [63:0] req_va_i = 64'h0, system_control_i = 64'h0;
    logic [47:0] user_table_base_reg_i = 48'h1_0000, kernel_table_base_reg_i = 48'h2_0000;
    logic [2:0] output_size_field_i = 3'h5;
    logic [3:0] delay = 4'h0;
    logic req_ready_o, mem_req_o, mem_ack_i, rsp_valid_o, rsp_ns_o, rsp_fault_o, translation_on_o;
    logic [47:0] mem_addr_o, rsp_pa_o;
    logic [63:0] mem_data_i, rsp_attr_o;
    logic [2:0] rsp_fault_code_o;
    int n_fail = 0;
    int checks = 0;
    atw_walker u_dut (.*);
    atw_table_mem u_mem (.clk_sys_i, .rst_n_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
        .delay_i(delay), .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
    // ----
    // access tasks
    // ----
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fault(input logic [2:0] code);
        chk({rsp_fault_o, rsp_fault_code_o, rsp_pa_o}, {1'b1, code, 48'h0});
    endtask
    task automatic endt(input string s);
        $display("test %s done", s);
    endtask
    task automatic sync();
        @(posedge clk_sys_i);
        instruction_sync_barrier_i <= 1'b1;
        @(posedge clk_sys_i);
        instruction_sync_barrier_i <= 1'b0;
    endtask
    task automatic xlate(input logic [63:0] va, input logic [2:0] wus);
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_va_i <= va;
        {req_write_i, req_user_i, req_secure_i} <= wus;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        for (int n = 0; n < 40 && rsp_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
        chk(rsp_valid_o, 1'b1);
        // results stand until the next request, so reading after this edge is safe
        @(posedge clk_sys_i);
    endtask
    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always #50 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        n_fail++;
        report_and_stop();
    end
    initial begin
        u_mem.store[48'h2_0008] = 64'h6000_0001;
        u_mem.store[48'h2_0010] = 64'h1_0000_0001;
        u_mem.store[48'h1_0008] = 64'h3_0043;
        u_mem.store[48'h1_0010] = 64'h3_0043;
        u_mem.store[48'h3_0028] = 64'hab_cdef_0043;
        u_mem.store[48'h3_0030] = 64'hc3;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        chk({req_ready_o, mem_req_o, rsp_valid_o, rsp_ns_o, translation_on_o}, 5'h12);
        chk(rsp_pa_o, 48'h0);
        sync();
        system_control_i <= system_control_i | 64'h1;
        xlate(64'h2005_abcd, 3'h2);
        chk({rsp_attr_o[7:0], rsp_pa_o}, 56'hff_0000_2005_abcd);
        xlate(64'h2005_abcd, 3'h3);
        chk(rsp_attr_o[7:0], 8'h00);
        sync();
        endt("translation off");
        xlate(64'hffff_fc00_2123_4567, 3'h0);
        chk({translation_on_o, rsp_ns_o, rsp_pa_o}, {2'h3, 48'h6123_4567});
        xlate(64'hffff_fc00_2123_4567, 3'h1);
        chk({rsp_ns_o, rsp_pa_o}, {1'b0, 48'h6123_4567});
        for (int i = 1; i < 3; i++) begin
            delay <= 4'(i * 5 - 5);
            xlate({33'h0, 2'(i), 29'h5_abcd}, 3'h2);
            chk({rsp_fault_o, rsp_pa_o}, {1'b0, 48'hab_cdef_abcd});
        end
        endt("walks");
        tag_enable_i <= 1'b1;
        sync();
        xlate(64'h5a00_0000_2005_abcd, 3'h2);
        chk(rsp_pa_o, 48'hab_cdef_abcd);
        tag_enable_i <= 1'b0;
        sync();
        xlate(64'h5a00_0000_2005_abcd, 3'h2);
        fault(3'h1);
        xlate(64'h0000_8000_0000_0000, 3'h0);
        fault(3'h1);
        endt("tagging");
        xlate(64'h6000_0000, 3'h2);
        fault(3'h2);
        xlate(64'hffff_fc00_2123_4567, 3'h2);
        fault(3'h2);
        xlate(64'h2006_0000, 3'h6);
        fault(3'h3);
        endt("faults");
        xlate(64'hffff_fc00_4000_0000, 3'h0);
        chk(rsp_pa_o, 48'h1_0000_0000);
        output_size_field_i <= 3'h0;
        sync();
        xlate(64'hffff_fc00_4000_0000, 3'h0);
        fault(3'h4);
        xlate(64'hffff_fc00_2123_4567, 3'h0);
        chk(rsp_fault_o, 1'b0);
        endt("output size");
        report_and_stop();
    end
endmodule
`default_nettype wire
